// ---- hw/fb_seq_params.svh ----
// Purpose: Constants for the framebuffer memory command sequencer
// Assumes: Included by bare name; definitions only
// Notes:   Commands are packed as {chip select, row strobe, column strobe, write enable}
`ifndef FB_SEQ_PARAMS_SVH
`define FB_SEQ_PARAMS_SVH

`define CMD_INHIBIT      4'hF
`define CMD_NOP          4'h7
`define CMD_ACTIVATE     4'h3
`define CMD_READ         4'h5
`define CMD_WRITE        4'h4
`define CMD_PRECHARGE    4'h2
`define CMD_MODE_LOAD    4'h0
`define CMD_REFRESH      4'h1

`define ADDR_W           11
`define ROW_W            11
`define COL_W            8
`define DATA_W           128
`define PRE_ALL_SDRAM    11'h400
`define PRE_ALL_SGRAM    11'h200
`define ADDR_ZERO        11'h000

`define MODE_BURST_ONE   3'h0
`define MODE_LAT_TWO     3'h2
`define MODE_LAT_THREE   3'h3

`define T_RP_CK          4
`define T_RCD_CK         3
`define T_RAS_CK         7
`define T_RC_CK          10
`define T_WR_CK          2
`define T_MRD_CK         2
`define MEM_CLK_NS       10
`define REF_PERIOD_MS    16
`define REF_COUNT        1024
`define REF_PERIOD_NS    (`REF_PERIOD_MS * 1000000)

`endif

// ---- hw/fb_seq_pkg.sv ----
// Purpose: Types shared by the framebuffer memory command sequencer
// Assumes: Nothing beyond a SystemVerilog compiler
// Notes:   State codes above ST_WAIT are illegal
package fb_seq_pkg;

	typedef enum logic [3:0]
	{
		ST_INIT_PRE   = 4'h0,
		ST_MODE       = 4'h1,
		ST_IDLE       = 4'h2,
		ST_CLOSE      = 4'h3,
		ST_OPEN       = 4'h4,
		ST_ACCESS     = 4'h5,
		ST_READ_WAIT  = 4'h6,
		ST_REF_PRE    = 4'h7,
		ST_REF        = 4'h8,
		ST_WAIT       = 4'h9
	} mem_state_type;

	typedef enum logic [2:0]
	{
		AK_NONE    = 3'h0,
		AK_ROW     = 3'h1,
		AK_COL     = 3'h2,
		AK_PRE_ONE = 3'h3,
		AK_PRE_ALL = 3'h4,
		AK_MODE    = 3'h5
	} addr_kind_type;

endpackage

// ---- hw/level_synchronizer.sv ----
// Purpose: Two flip-flop synchroniser for levels and toggles
// Assumes: Source is stable across at least two destination edges
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module level_synchronizer #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule // level_synchronizer
`default_nettype wire

// ---- hw/framebuffer_sdram_sgram_sequencer.sv ----
// Overview of operation
// - Single-beat accesses, one command per clock possible
// - Activate row before read or write
// - Column address presented with read/write command
// - Memory port sampled on forwarded clock rise
// - Command encoding on four active-low strobes
// - SDRAM: bank pin, row, column mapping
// - SDRAM precharge: bit 10 selects all
// - SGRAM: both selects, bit 10 bank
// - SGRAM precharge: bit 9 selects all
// - Mode load drives opcode on address
// - Clock enable high, special function low
// - Mask gates writes now, reads two later
// - Write data driven only with write
// - First command at first edge after reset
// - Precharge all, load mode, then operate
// - Mode burst length field zero
// - Read latency two or three, capture then
// - Reads pipeline and return in order; here each read waits for its capture before the next command
// - Per-bank clock outputs plus feedback loop
// - SDRAM: second select becomes bank line
// - SGRAM two banks: select per bank
// - 1024 refreshes per 16 ms
// - Four clocks after precharge before next
//
// Purpose: Framebuffer memory command sequencer, client port on sys_clk
// Assumes: Configuration inputs are static after reset; mem_clk is the memory clock
// Notes:   Data bus is 128 wide; SDRAM mode uses the low 64 bits
`include "fb_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module framebuffer_sdram_sgram_sequencer
	import fb_seq_pkg::*;
#(
	parameter int MEM_CLK_PERIOD_NS       = `MEM_CLK_NS,
	parameter int REFRESH_INTERVAL_CYCLES = `REF_PERIOD_NS / `REF_COUNT / MEM_CLK_PERIOD_NS
) (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                mem_clk,
	input  wire logic                sgram_mode,
	input  wire logic                two_ext_banks,
	input  wire logic                read_latency_three,
	input  wire logic                req_valid,
	output logic                     req_ready,
	input  wire logic                req_write,
	input  wire logic                req_ext_bank,
	input  wire logic                req_bank,
	input  wire logic [`ROW_W-1:0]   req_row,
	input  wire logic [`COL_W-1:0]   req_col,
	input  wire logic [`DATA_W-1:0]  req_wdata,
	output logic                     resp_valid,
	output logic [`DATA_W-1:0]       resp_rdata,
	output logic                     init_done,
	output logic                     mem_clock_bank_first,
	output logic                     mem_clock_bank_second,
	output logic                     mem_clock_loop_out,
	input  wire logic                mem_clock_loop_in,
	output logic                     mem_chip_select_first_n,
	output logic                     mem_chip_select_second_or_bank_n,
	output logic                     mem_row_strobe_n,
	output logic                     mem_column_strobe_n,
	output logic                     mem_write_enable_n,
	output logic [`ADDR_W-1:0]       mem_address_lines,
	output logic                     mem_data_mask,
	output logic                     mem_clock_enable,
	output logic                     special_function_select,
	output logic [`DATA_W-1:0]       mem_data_bus_wide_out,
	input  wire logic [`DATA_W-1:0]  mem_data_bus_wide_in,
	output logic                     mem_data_bus_wide_oe_n
);

	localparam logic [3:0] RP_WAIT  = 4'(`T_RP_CK - 1);
	localparam logic [3:0] RCD_WAIT = 4'(`T_RCD_CK - 1);
	localparam logic [3:0] RC_WAIT  = 4'(`T_RC_CK - 1);
	localparam logic [3:0] MRD_WAIT = 4'(`T_MRD_CK - 1);
	localparam logic [3:0] RAS_GAP  = 4'(`T_RAS_CK - 1);
	localparam logic [3:0] WR_GAP   = 4'(`T_WR_CK);
	localparam logic [15:0] REF_RELOAD = 16'(REFRESH_INTERVAL_CYCLES - 1);

	// System clock side
	logic                 busy_q, req_tgl_q, hold_write_q, hold_ext_q, hold_bank_q;
	logic                 ack_prev_q, resp_valid_q, ack_sys, init_sys;
	logic [`ROW_W-1:0]    hold_row_q;
	logic [`COL_W-1:0]    hold_col_q;
	logic [`DATA_W-1:0]   hold_wdata_q, resp_rdata_q;
	wire                  accept;
	wire                  ack_seen;

	// Memory clock side
	mem_state_type        state_q, state_d, ret_q, ret_d;
	addr_kind_type        kind_d;
	logic [3:0]           cnt_q, cnt_d, cmd_d, cmd_q, since_act_q, since_wr_q, open_q;
	logic                 all_d, act_issue, rd_issue, wr_issue, pre_one, pre_all;
	logic                 ref_issue, mode_issue, done, req_mem, req_prev_q, ack_tgl_q;
	logic                 init_mem_q, cs_first_q, cs_second_q, dqm_q, cke_q, oe_n_q;
	logic                 ref_due_q;
	logic [2:0]           cfg_mem, rd_sh_q;
	logic [`ADDR_W-1:0]   addr_q;
	logic [`DATA_W-1:0]   dout_q, rdata_q;
	logic [15:0]          ref_cnt_q;
	logic [`ROW_W-1:0]    open_row_q [4];

	// Client handshake: fields held stable until the memory side toggles back
	assign accept     = req_valid & req_ready;
	assign ack_seen   = ack_sys ^ ack_prev_q;
	assign req_ready  = ~busy_q & init_sys;
	assign resp_valid = resp_valid_q;
	assign resp_rdata = resp_rdata_q;
	assign init_done  = init_sys;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_q       <= 1'b0;
			req_tgl_q    <= 1'b0;
			ack_prev_q   <= 1'b0;
			resp_valid_q <= 1'b0;
			hold_write_q <= 1'b0;
			hold_ext_q   <= 1'b0;
			hold_bank_q  <= 1'b0;
			hold_row_q   <= '0;
			hold_col_q   <= '0;
			hold_wdata_q <= '0;
			resp_rdata_q <= '0;
		end
		else
		begin
			busy_q       <= accept | (busy_q & ~ack_seen);
			req_tgl_q    <= req_tgl_q ^ accept;
			ack_prev_q   <= ack_sys;
			resp_valid_q <= ack_seen;
			if (accept)
			begin
				hold_write_q <= req_write;
				hold_ext_q   <= req_ext_bank;
				hold_bank_q  <= req_bank;
				hold_row_q   <= req_row;
				hold_col_q   <= req_col;
				hold_wdata_q <= req_wdata;
			end
			if (ack_seen & ~hold_write_q)
				resp_rdata_q <= rdata_q;
		end
	end

	level_synchronizer #(.WIDTH(1)) u_ack_sync
		(.clk(sys_clk), .rst(rst), .d(ack_tgl_q), .q(ack_sys));
	level_synchronizer #(.WIDTH(1)) u_init_sync
		(.clk(sys_clk), .rst(rst), .d(init_mem_q), .q(init_sys));
	level_synchronizer #(.WIDTH(1)) u_req_sync
		(.clk(mem_clk), .rst(rst), .d(req_tgl_q), .q(req_mem));

	// mode select; left out of reset so the mapping has settled
	// before the first precharge leaves at the first edge after release
	level_synchronizer #(.WIDTH(3)) u_cfg_sync
		(.clk(mem_clk), .rst(1'b0), .d({read_latency_three, two_ext_banks, sgram_mode}),
		.q(cfg_mem));

	wire                sgram   = cfg_mem[0];
	wire                two_ext = cfg_mem[1] & cfg_mem[0];
	wire                lat3    = cfg_mem[2];
	wire                pend    = req_mem ^ req_prev_q;
	wire                ext_eff = two_ext & hold_ext_q;
	wire [1:0]          idx     = {ext_eff, hold_bank_q};
	wire [`ROW_W-1:0]   row_eff = sgram ? {1'b0, hold_row_q[9:0]} : hold_row_q;
	wire                row_hit = open_q[idx] & (open_row_q[idx] == row_eff);
	wire                pre_ok  = (since_act_q >= RAS_GAP) & (since_wr_q >= WR_GAP);
	wire                rd_pins = (cmd_q == `CMD_READ);
	wire                capture = lat3 ? rd_sh_q[2] : rd_sh_q[1];

	// SDRAM row, column on low bits
	wire [`ADDR_W-1:0]  addr_row = sgram ? {hold_bank_q, hold_row_q[9:0]} : hold_row_q;
	wire [`ADDR_W-1:0]  addr_col = sgram ? {hold_bank_q, 2'b00, hold_col_q}
	                                     : {3'b000, hold_col_q};
	// SGRAM single precharge, bit 9 low
	wire [`ADDR_W-1:0]  addr_pre1 = sgram ? {hold_bank_q, 10'h000} : `ADDR_ZERO;
	wire [`ADDR_W-1:0]  addr_prea = sgram ? `PRE_ALL_SGRAM : `PRE_ALL_SDRAM;
	// burst length zero, type bit zero
	wire [`ADDR_W-1:0]  addr_mode = {4'h0, lat3 ? `MODE_LAT_THREE : `MODE_LAT_TWO,
	                                 1'b0, `MODE_BURST_ONE};
	wire [`ADDR_W-1:0]  addr_d = (kind_d == AK_ROW)     ? addr_row  :
	                             (kind_d == AK_COL)     ? addr_col  :
	                             (kind_d == AK_PRE_ONE) ? addr_pre1 :
	                             (kind_d == AK_PRE_ALL) ? addr_prea :
	                             (kind_d == AK_MODE)    ? addr_mode : addr_q;
	// SDRAM second select carries the bank bit; opcode bit 11 is zero
	wire                bank_pin_d = (kind_d == AK_ROW) | (kind_d == AK_COL) |
	                                 (kind_d == AK_PRE_ONE) ? hold_bank_q : 1'b0;
	wire                cs_first_d  = (two_ext & ~all_d & ext_eff) ? 1'b1 : cmd_d[3];
	wire                cs_second_d = ~sgram ? bank_pin_d :
	                                  (two_ext & ~all_d & ~ext_eff) ? 1'b1 : cmd_d[3];
	// write mask now, read mask two before data
	wire                dqm_d = ~(wr_issue | (rd_issue & ~lat3) | (rd_pins & lat3));

	always_comb
	begin
		state_d    = state_q;
		ret_d      = ret_q;
		cnt_d      = cnt_q;
		cmd_d      = `CMD_NOP;
		kind_d     = AK_NONE;
		all_d      = 1'b1;
		act_issue  = 1'b0;
		rd_issue   = 1'b0;
		wr_issue   = 1'b0;
		pre_one    = 1'b0;
		pre_all    = 1'b0;
		ref_issue  = 1'b0;
		mode_issue = 1'b0;
		done       = 1'b0;
		unique case (state_q)
			// issued at first edge after reset
			ST_INIT_PRE:
			begin
				cmd_d   = `CMD_PRECHARGE;
				kind_d  = AK_PRE_ALL;
				pre_all = 1'b1;
				state_d = ST_WAIT;
				cnt_d   = RP_WAIT;
				ret_d   = ST_MODE;
			end
			ST_MODE:
			begin
				cmd_d      = `CMD_MODE_LOAD;
				kind_d     = AK_MODE;
				mode_issue = 1'b1;
				state_d    = ST_WAIT;
				cnt_d      = MRD_WAIT;
				ret_d      = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (ref_due_q)
					state_d = ST_REF_PRE;
				else if (pend)
					state_d = row_hit ? ST_ACCESS : (open_q[idx] ? ST_CLOSE : ST_OPEN);
			end
			ST_CLOSE:
			begin
				if (pre_ok)
				begin
					cmd_d   = `CMD_PRECHARGE;
					kind_d  = AK_PRE_ONE;
					all_d   = 1'b0;
					pre_one = 1'b1;
					state_d = ST_WAIT;
					cnt_d   = RP_WAIT;
					ret_d   = ST_OPEN;
				end
			end
			ST_OPEN:
			begin
				cmd_d     = `CMD_ACTIVATE;
				kind_d    = AK_ROW;
				all_d     = 1'b0;
				act_issue = 1'b1;
				state_d   = ST_WAIT;
				cnt_d     = RCD_WAIT;
				ret_d     = ST_ACCESS;
			end
			ST_ACCESS:
			begin
				cmd_d  = hold_write_q ? `CMD_WRITE : `CMD_READ;
				kind_d = AK_COL;
				all_d  = 1'b0;
				if (hold_write_q)
				begin
					wr_issue = 1'b1;
					done     = 1'b1;
					state_d  = ST_IDLE;
				end
				else
				begin
					rd_issue = 1'b1;
					state_d  = ST_READ_WAIT;
				end
			end
			ST_READ_WAIT:
			begin
				if (capture)
				begin
					done    = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_REF_PRE:
			begin
				if (pre_ok)
				begin
					cmd_d   = `CMD_PRECHARGE;
					kind_d  = AK_PRE_ALL;
					pre_all = 1'b1;
					state_d = ST_WAIT;
					cnt_d   = RP_WAIT;
					ret_d   = ST_REF;
				end
			end
			ST_REF:
			begin
				cmd_d     = `CMD_REFRESH;
				ref_issue = 1'b1;
				state_d   = ST_WAIT;
				cnt_d     = RC_WAIT;
				ret_d     = ST_IDLE;
			end
			ST_WAIT:
			begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1)
					state_d = ret_q;
			end
			default:
				state_d = ST_INIT_PRE;
		endcase
	end

	// Reset releases straight into the first command; a reset synchroniser
	// here would cost the first edge after release
	// memory command, address, mask, clock enable and data outputs launched from mem_clk flops
	// read flags shift in command order
	// Refresh request: a new expiry wins over the clear
	always_ff @(posedge mem_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q     <= ST_INIT_PRE;
			ret_q       <= ST_IDLE;
			cnt_q       <= 4'h0;
			cmd_q       <= `CMD_INHIBIT;
			addr_q      <= `ADDR_ZERO;
			cs_first_q  <= 1'b1;
			cs_second_q <= 1'b1;
			dqm_q       <= 1'b1;
			cke_q       <= 1'b0;
			oe_n_q      <= 1'b1;
			dout_q      <= '0;
			rdata_q     <= '0;
			rd_sh_q     <= 3'h0;
			ref_cnt_q   <= REF_RELOAD;
			ref_due_q   <= 1'b0;
			req_prev_q  <= 1'b0;
			ack_tgl_q   <= 1'b0;
			init_mem_q  <= 1'b0;
			since_act_q <= 4'hF;
			since_wr_q  <= 4'hF;
		end
		else
		begin
			state_q     <= state_d;
			ret_q       <= ret_d;
			cnt_q       <= cnt_d;
			cmd_q       <= cmd_d;
			addr_q      <= addr_d;
			cs_first_q  <= cs_first_d;
			cs_second_q <= cs_second_d;
			dqm_q       <= dqm_d;
			cke_q       <= 1'b1;
			oe_n_q      <= ~wr_issue;
			rd_sh_q     <= {rd_sh_q[1:0], rd_pins};
			if (wr_issue)
				dout_q <= hold_wdata_q;
			if (capture)
				rdata_q <= mem_data_bus_wide_in;
			ref_cnt_q   <= (ref_cnt_q == 16'h0000) ? REF_RELOAD : ref_cnt_q - 16'h0001;
			ref_due_q   <= (ref_cnt_q == 16'h0000) | (ref_due_q & ~ref_issue);
			if (done)
				req_prev_q <= req_mem;
			ack_tgl_q   <= ack_tgl_q ^ done;
			init_mem_q  <= init_mem_q | mode_issue;
			since_act_q <= act_issue ? 4'h0 : since_act_q + {3'h0, since_act_q != 4'hF};
			since_wr_q  <= wr_issue ? 4'h0 : since_wr_q + {3'h0, since_wr_q != 4'hF};
		end
	end

	always_ff @(posedge mem_clk or posedge rst)
	begin
		if (rst)
		begin
			open_q <= 4'h0;
			for (int i = 0; i < 4; i++)
				open_row_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (pre_all | (pre_one & (idx == 2'(i))))
					open_q[i] <= 1'b0;
				else if (act_issue & (idx == 2'(i)))
				begin
					open_q[i]     <= 1'b1;
					open_row_q[i] <= row_eff;
				end
			end
		end
	end

	// forwarded clocks; loop input kept for board delay matching only
	assign mem_clock_bank_first             = mem_clk;
	assign mem_clock_bank_second            = mem_clk;
	assign mem_clock_loop_out               = mem_clk;
	assign mem_chip_select_first_n          = cs_first_q;
	assign mem_chip_select_second_or_bank_n = cs_second_q;
	assign mem_row_strobe_n                 = cmd_q[2];
	assign mem_column_strobe_n              = cmd_q[1];
	assign mem_write_enable_n               = cmd_q[0];
	assign mem_address_lines                = addr_q;
	assign mem_data_mask                    = dqm_q;
	assign mem_clock_enable                 = cke_q;
	assign special_function_select          = 1'b0;
	assign mem_data_bus_wide_out            = dout_q;
	assign mem_data_bus_wide_oe_n           = oe_n_q;

endmodule // framebuffer_sdram_sgram_sequencer
`default_nettype wire

// ---- sim/fb_seq_checker.sv ----
// Purpose: Assertions on the memory command port of the sequencer
// Assumes: Bound into the sequencer; every check runs on mem_clk
// Notes:   The second select counts as a select only in SGRAM mode
`include "fb_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fb_seq_checker (
	input wire logic               mem_clk,
	input wire logic               rst,
	input wire logic               sgram_mode,
	input wire logic               two_ext_banks,
	input wire logic               read_latency_three,
	input wire logic               mem_chip_select_first_n,
	input wire logic               mem_chip_select_second_or_bank_n,
	input wire logic               mem_row_strobe_n,
	input wire logic               mem_column_strobe_n,
	input wire logic               mem_write_enable_n,
	input wire logic [`ADDR_W-1:0] mem_address_lines,
	input wire logic               mem_data_mask,
	input wire logic               mem_clock_enable,
	input wire logic               special_function_select,
	input wire logic               mem_data_bus_wide_oe_n
);
	logic       sel, act, rd, wr, pre, mode, op_any, all_b, seen_q;
	logic [2:0] op;

	assign sel = !mem_chip_select_first_n || (sgram_mode && !mem_chip_select_second_or_bank_n);
	assign op = {mem_row_strobe_n, mem_column_strobe_n, mem_write_enable_n};
	assign act = sel && op == 3'h3;
	assign rd = sel && op == 3'h5;
	assign wr = sel && op == 3'h4;
	assign pre = sel && op == 3'h2;
	assign mode = sel && op == 3'h0;
	assign op_any = act || rd || wr;
	assign all_b = sgram_mode ? mem_address_lines[9] : mem_address_lines[10];

	always_ff @(posedge mem_clk or posedge rst)
	begin
		if (rst)
			seen_q <= 1'b0;
		else if (mode)
			seen_q <= 1'b1;
	end

	default clocking dc @(posedge mem_clk);
	endclocking
	default disable iff (rst);

	property p_first_cmd;
		$past(rst, 2) && !$past(rst) |-> pre && all_b;
	endproperty
	a_first_cmd: assert property (p_first_cmd)
		else $error("first command is not precharge all");
	property p_cmd_pins;
		sel |-> mem_clock_enable && !special_function_select;
	endproperty
	a_cmd_pins: assert property (p_cmd_pins)
		else $error("clock enable or special select wrong");
	property p_bus_drive;
		(wr || !mem_data_bus_wide_oe_n) |-> wr && !mem_data_bus_wide_oe_n;
	endproperty
	a_bus_drive: assert property (p_bus_drive)
		else $error("data bus driven outside a write");
	property p_write_mask;
		wr |-> !mem_data_mask;
	endproperty
	a_write_mask: assert property (p_write_mask)
		else $error("mask high on write");
	property p_read_mask;
		rd |-> (!read_latency_three && !mem_data_mask) or (read_latency_three ##1 !mem_data_mask);
	endproperty
	a_read_mask: assert property (p_read_mask)
		else $error("mask high on read data");
	property p_col_addr;
		(rd || wr) |-> !all_b;
	endproperty
	a_col_addr: assert property (p_col_addr)
		else $error("auto bit set on column access");
	property p_both_sel;
		sgram_mode && !two_ext_banks && sel
			|-> mem_chip_select_first_n == mem_chip_select_second_or_bank_n;
	endproperty
	a_both_sel: assert property (p_both_sel)
		else $error("selects differ in single bank SGRAM");
	property p_pre_gap;
		pre |=> (!op_any) [*3];
	endproperty
	a_pre_gap: assert property (p_pre_gap)
		else $error("access too soon after precharge");
	property p_mode_first;
		op_any |-> seen_q;
	endproperty
	a_mode_first: assert property (p_mode_first)
		else $error("access before mode load");
	property p_burst_one;
		mode |-> mem_address_lines[2:0] == `MODE_BURST_ONE;
	endproperty
	a_burst_one: assert property (p_burst_one)
		else $error("burst length field not zero");
	property p_latency;
		mode |-> mem_address_lines[6:4] == (read_latency_three ? `MODE_LAT_THREE : `MODE_LAT_TWO);
	endproperty
	a_latency: assert property (p_latency)
		else $error("latency field wrong");

	c_read3: cover property (rd && read_latency_three);
	c_write: cover property (wr);
	c_refresh: cover property (sel && op == 3'h1);
	c_pre_one: cover property (pre && !all_b);
endmodule // fb_seq_checker
`default_nettype wire

// ---- sim/fb_mem_model.sv ----
// Purpose: Behavioural SDRAM/SGRAM devices on the memory port
// Assumes: Commands sampled on the forwarded bank clock
// Notes:   Faults are counted, not fatal, so the bench can report them
`include "fb_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fb_mem_model (
	input  wire logic               mem_clock_bank_first,
	input  wire logic               sgram_mode,
	input  wire logic               mem_chip_select_first_n,
	input  wire logic               mem_chip_select_second_or_bank_n,
	input  wire logic               mem_row_strobe_n,
	input  wire logic               mem_column_strobe_n,
	input  wire logic               mem_write_enable_n,
	input  wire logic [`ADDR_W-1:0] mem_address_lines,
	input  wire logic               mem_data_mask,
	input  wire logic               mem_data_bus_wide_oe_n,
	input  wire logic [`DATA_W-1:0] mem_data_bus_wide_out,
	output logic      [`DATA_W-1:0] mem_data_bus_wide_in,
	output logic      [7:0]         faults
);
	logic [`DATA_W-1:0] store [int];
	logic [`DATA_W-1:0] slot_d [4];
	logic               slot_v [4] = '{4{1'b0}};
	int                 open_row [4] = '{4{-1}};
	int                 pre_at [4] = '{4{-8}};
	int                 cyc = 0;
	int                 lat = 2;
	logic               mode_ok = 1'b0;

	initial
	begin
		faults = 8'h00;
		mem_data_bus_wide_in = 128'h0;
	end

	always @(posedge mem_clock_bank_first)
	begin : sample
		logic [2:0] op;
		logic       all;
		int         b, x, k;
		op = {mem_row_strobe_n, mem_column_strobe_n, mem_write_enable_n};
		all = sgram_mode ? mem_address_lines[9] : mem_address_lines[10];
		b = sgram_mode ? mem_address_lines[10] : mem_chip_select_second_or_bank_n;
		cyc++;
		for (int i = 0; i < 3; i++)
		begin
			slot_v[i] = slot_v[i + 1];
			slot_d[i] = slot_d[i + 1];
		end
		slot_v[3] = 1'b0;
		for (int e = 0; e < 2; e++)
		begin
			if (e == 0 ? !mem_chip_select_first_n : sgram_mode && !mem_chip_select_second_or_bank_n)
			begin
				x = e * 2 + b;
				k = (x * 4096 + open_row[x]) * 256 + mem_address_lines[7:0];
				if (op == 3'h3)
				begin
					if (!mode_ok || open_row[x] >= 0 || cyc - pre_at[x] < `T_RP_CK)
						faults++;
					open_row[x] = sgram_mode ? mem_address_lines[9:0] : mem_address_lines;
				end
				else if (op == 3'h5 || op == 3'h4)
				begin
					if (open_row[x] < 0 || all)
						faults++;
					if (op[0])
					begin
						slot_v[lat - 1] = 1'b1;
						slot_d[lat - 1] = store.exists(k) ? store[k] : ~128'h0;
					end
					// Mask low lets the write in
					else if (mem_data_mask || mem_data_bus_wide_oe_n)
						faults++;
					else
						store[k] = mem_data_bus_wide_out;
				end
				else if (op == 3'h2)
				begin
					for (int j = 0; j < 2; j++)
						if (all || j == b)
						begin
							open_row[e * 2 + j] = -1;
							pre_at[e * 2 + j] = cyc;
						end
				end
				else if (op == 3'h0)
				begin
					lat = mem_address_lines[6:4];
					mode_ok = 1'b1;
				end
				else if (op == 3'h1 && (open_row[e * 2] >= 0 || open_row[e * 2 + 1] >= 0))
					faults++;
			end
		end
		// Idle bus toggles so a stale capture cannot match by luck
		mem_data_bus_wide_in <= slot_v[0] ? slot_d[0] : ~mem_data_bus_wide_in;
	end
endmodule // fb_mem_model
`default_nettype wire

// ---- sim/framebuffer_sdram_sgram_sequencer_test.sv ----
// Purpose: Self-checking bench for the framebuffer memory sequencer
// Assumes: One request outstanding at a time
// Notes:   Each memory mode is entered through a fresh reset
`include "fb_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module framebuffer_sdram_sgram_sequencer_test;
	logic               sys_clk = 1'b0, mem_clk = 1'b0, rst = 1'b1;
	logic               sgram_mode = 1'b0, two_ext_banks = 1'b0, read_latency_three = 1'b0;
	logic               req_valid = 1'b0, req_write = 1'b0, req_ext_bank = 1'b0, req_bank = 1'b0;
	logic [`ROW_W-1:0]  req_row = `ADDR_ZERO;
	logic [`COL_W-1:0]  req_col = 8'h00;
	logic [`DATA_W-1:0] req_wdata = 128'h0, resp_rdata, mem_data_bus_wide_out, mem_data_bus_wide_in;
	logic               req_ready, resp_valid, init_done, mem_clock_bank_first;
	logic               mem_clock_bank_second, mem_clock_loop_out, mem_chip_select_first_n;
	logic               mem_chip_select_second_or_bank_n, mem_row_strobe_n, mem_column_strobe_n;
	logic               mem_write_enable_n, mem_data_mask, mem_clock_enable;
	logic               special_function_select, mem_data_bus_wide_oe_n;
	logic [`ADDR_W-1:0] mem_address_lines;
	logic [7:0]         faults;
	int                 failures = 0, total_checks = 0;
	logic [`DATA_W-1:0] ref_mem [int];

	always #25 sys_clk = ~sys_clk;
	always #3 mem_clk = ~mem_clk;

	framebuffer_sdram_sgram_sequencer #(.REFRESH_INTERVAL_CYCLES(40)) DUT (
		.sys_clk, .rst, .mem_clk, .sgram_mode, .two_ext_banks, .read_latency_three,
		.req_valid, .req_ready, .req_write, .req_ext_bank, .req_bank, .req_row, .req_col,
		.req_wdata, .resp_valid, .resp_rdata, .init_done, .mem_clock_bank_first,
		.mem_clock_bank_second, .mem_clock_loop_out, .mem_clock_loop_in(mem_clock_loop_out),
		.mem_chip_select_first_n, .mem_chip_select_second_or_bank_n, .mem_row_strobe_n,
		.mem_column_strobe_n, .mem_write_enable_n, .mem_address_lines, .mem_data_mask,
		.mem_clock_enable, .special_function_select, .mem_data_bus_wide_out,
		.mem_data_bus_wide_in, .mem_data_bus_wide_oe_n);

	fb_mem_model memory (.mem_clock_bank_first, .sgram_mode, .mem_chip_select_first_n,
		.mem_chip_select_second_or_bank_n, .mem_row_strobe_n, .mem_column_strobe_n,
		.mem_write_enable_n, .mem_address_lines, .mem_data_mask, .mem_data_bus_wide_oe_n,
		.mem_data_bus_wide_out, .mem_data_bus_wide_in, .faults);

	task automatic check(input string what, input logic [`DATA_W-1:0] exp,
		input logic [`DATA_W-1:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	// SDRAM carries only the low half of the data bus
	task automatic access(input logic [`DATA_W-1:0] exp, input logic known);
		logic [`DATA_W-1:0] lanes;
		int                 n;
		lanes = sgram_mode ? ~128'h0 : {64'h0, ~64'h0};
		req_valid = 1'b1;
		for (n = 0; n < 400 && !req_ready; n++)
			tick();
		tick();
		req_valid = 1'b0;
		for (n = 0; n < 400 && !resp_valid; n++)
			tick();
		check("response", 128'h1, {127'h0, resp_valid});
		if (!req_write && known)
			check("read data", exp & lanes, resp_rdata & lanes);
	endtask

	initial
	begin : main
		logic [`DATA_W-1:0] d;
		logic               known;
		int                 c, i, k;
		void'($urandom(61992));
		for (c = 0; c < 4; c++)
		begin
			tick();
			rst = 1'b1;
			sgram_mode = c[1];
			read_latency_three = c[0];
			two_ext_banks = c == 3;
			repeat (8) @(posedge sys_clk);
			#1;
			check("ready in reset", 128'h0, {127'h0, req_ready});
			rst = 1'b0;
			for (i = 0; i < 200 && !init_done; i++)
				tick();
			check("init done", 128'h1, {127'h0, init_done});
			for (i = 0; i < 40; i++)
			begin
				req_write = 1'($urandom_range(1));
				req_ext_bank = 1'($urandom_range(1));
				req_bank = 1'($urandom_range(1));
				req_row = $urandom_range(3) == 3 ? (sgram_mode ? 11'h3FF : 11'h7FF)
					: 11'($urandom_range(2));
				req_col = $urandom_range(1) ? 8'hFF : 8'($urandom_range(3));
				req_wdata = {$urandom, $urandom, $urandom, $urandom};
				k = int'({c[1:0], req_ext_bank & two_ext_banks, req_bank, req_row, req_col});
				known = ref_mem.exists(k);
				d = known ? ref_mem[k] : 128'h0;
				if (req_write)
					ref_mem[k] = req_wdata;
				access(d, known);
			end
		end
		check("memory faults", 128'h0, {120'h0, faults});
		stop_test();
	end

	initial
	begin
		#3000000;
		failures++;
		stop_test();
	end
endmodule // framebuffer_sdram_sgram_sequencer_test

bind framebuffer_sdram_sgram_sequencer fb_seq_checker chk (.mem_clk, .rst, .sgram_mode,
	.two_ext_banks, .read_latency_three, .mem_chip_select_first_n,
	.mem_chip_select_second_or_bank_n, .mem_row_strobe_n, .mem_column_strobe_n,
	.mem_write_enable_n, .mem_address_lines, .mem_data_mask, .mem_clock_enable,
	.special_function_select, .mem_data_bus_wide_oe_n);
`default_nettype wire
